// [hdl/uidr_pkg.sv]
// Constants for the unique-id and calibration ROM register bank.
// Assumes a 16-bit register port addressed by 8-bit word addresses.
package uidr_pkg;

  // Port widths
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 16;

  // Word addresses of the ROM bank
  localparam logic [7:0] ADDR_ID_LO  = 8'h8C;
  localparam logic [7:0] ADDR_ID_MID = 8'h8D;
  localparam logic [7:0] ADDR_ID_TOP = 8'h8E;
  localparam logic [7:0] ADDR_CAL_A  = 8'h8F;
  localparam logic [7:0] ADDR_CAL_RF = 8'h90;
  localparam logic [7:0] ADDR_CAL_B  = 8'h91;
  localparam logic [7:0] ADDR_CAL_C  = 8'h92;
  // Word addresses of the check control and status
  localparam logic [7:0] ADDR_CTRL   = 8'hA0;
  localparam logic [7:0] ADDR_STAT   = 8'hA1;

  // ROM geometry
  localparam int unsigned ROM_WORDS = 7;
  localparam int unsigned ROM_BYTES = 14;
  localparam logic [3:0]  LAST_BYTE = 4'hD;

  // Values after reset
  localparam logic [39:0] RST_SERIAL = 40'h00_0000_0000;
  localparam logic [7:0]  RST_TRIM   = 8'h00;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic        RST_CHK_EN = 1'b1;

  // Field positions
  localparam int unsigned ID_FORCE_BIT = 0;
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_GO_BIT  = 1;
  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned ST_DONE_BIT  = 1;
  localparam int unsigned ST_OK_BIT    = 2;
  localparam int unsigned ST_IDV_BIT   = 3;
  localparam int unsigned ST_CRC_LSB   = 8;
  localparam logic [5:0]  ID_MIN_ONES  = 6'h02;

  // Check code, x^8+x^6+x^3+x^2+1
  localparam logic [7:0] CRC_POLY_KOOP = 8'hA6;
  localparam logic [7:0] CRC_POLY = {CRC_POLY_KOOP[6:0], 1'b1};
  localparam logic [7:0] CRC_INIT = 8'h00;

  // Check sequencer states
  typedef enum logic [1:0] {
    UIDR_IDLE = 2'b00,
    UIDR_RUN  = 2'b01,
    UIDR_CMP  = 2'b10
  } uidr_state_t;

  // Word address to ROM index, valid only inside the bank
  function automatic logic [2:0] uidr_rom_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - ADDR_ID_LO;
    return d[2:0];
  endfunction : uidr_rom_idx

  // True for any word address of the ROM bank
  function automatic logic uidr_in_bank(input logic [7:0] a);
    return (a >= ADDR_ID_LO) && (a <= ADDR_CAL_C);
  endfunction : uidr_in_bank

endpackage : uidr_pkg

// [hdl/uidr_rom.sv]
// Fixed ROM image of the serial number and calibration words.
// Assumes contents are set at build time; two independent read ports.
`timescale 1ns/1ps
`default_nettype none
module uidr_rom
  import uidr_pkg::*;
#(
  parameter logic [39:0] UNIQUE_SERIAL   = RST_SERIAL,
  parameter logic [7:0]  TRIM_BYTE_UPPER = RST_TRIM,
  parameter logic [15:0] CAL_WORD_A      = RST_WORD,
  parameter logic [15:0] CAL_REF_TRIM    = RST_WORD,
  parameter logic [15:0] CAL_WORD_B      = RST_WORD,
  parameter logic [15:0] CAL_WORD_C      = RST_WORD
) (
  // Read ports
  input  wire logic [2:0]  idx_a_in,
  input  wire logic [2:0]  idx_b_in,
  output logic      [15:0] word_a_out,
  output logic      [15:0] word_b_out,
  // Whole serial as read back
  output logic      [39:0] serial_out
);

  logic [15:0] image [ROM_WORDS];
  logic [39:0] serial;

  // Lowest serial bit is always one whatever was programmed
  always_comb begin
    serial = UNIQUE_SERIAL;
    serial[ID_FORCE_BIT] = 1'b1;
  end

  // Word layout of the bank
  always_comb begin
    image[0] = serial[15:0];
    image[1] = serial[31:16];
    image[2] = {TRIM_BYTE_UPPER, serial[39:32]};
    image[3] = CAL_WORD_A;
    image[4] = CAL_REF_TRIM;
    image[5] = CAL_WORD_B;
    image[6] = CAL_WORD_C;
  end

  // Out-of-range index reads zero
  assign word_a_out = (idx_a_in < 3'h7) ? image[idx_a_in] : RST_WORD;
  assign word_b_out = (idx_b_in < 3'h7) ? image[idx_b_in] : RST_WORD;
  assign serial_out = serial;

endmodule : uidr_rom
`default_nettype wire

// [hdl/uidr_crc8.sv]
// Byte-wide CRC-8 engine, MSB first, no final inversion.
// Assumes the caller clears it before the first byte of a pass.
`timescale 1ns/1ps
`default_nettype none
module uidr_crc8
  import uidr_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  // Byte stream
  input  wire logic       clear_in,
  input  wire logic       valid_in,
  input  wire logic [7:0] byte_in,
  // Running remainder
  output logic      [7:0] crc_out
);

  logic [7:0] crc_r;
  logic [7:0] crc_nxt;

  // Eight shift steps of the divider in one cycle
  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_step

  // Clear beats a byte arriving in the same cycle
  always_comb begin
    crc_nxt = crc_r;
    if (clear_in) begin
      crc_nxt = CRC_INIT;
    end else if (valid_in) begin
      crc_nxt = crc_step(crc_r, byte_in);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      crc_r <= CRC_INIT;
    end else if (ce_in) begin
      crc_r <= crc_nxt;
    end
  end

  assign crc_out = crc_r;

endmodule : uidr_crc8
`default_nettype wire

// [hdl/uidr_regs.sv]
// Read-only serial number and calibration register bank with ROM check.
// Assumes a same-clock register master with one-cycle strobes, and a
// check code supplied by the neighbouring ROM word on the same clock.
//
// Overview of operation
// - Low serial word readable at 0x8C.
// - Bit 0 of low serial word reads one.
// - Middle serial word readable at 0x8D.
// - 0x8E: serial top byte, trim byte above.
// - Bank is CRC-checked ROM; calibration resets zero.
// - Check code uses polynomial 0xA6.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module uidr_regs
  import uidr_pkg::*;
#(
  parameter logic [39:0] UNIQUE_SERIAL   = RST_SERIAL,
  parameter logic [7:0]  TRIM_BYTE_UPPER = RST_TRIM,
  parameter logic [15:0] CAL_WORD_A      = RST_WORD,
  parameter logic [15:0] CAL_REF_TRIM    = RST_WORD,
  parameter logic [15:0] CAL_WORD_B      = RST_WORD,
  parameter logic [15:0] CAL_WORD_C      = RST_WORD
) (
  // Clock, reset, enable
  input  wire logic          ref_clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          ce_in,
  // Register port
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [DW-1:0] wdata_in,
  input  wire logic          wr_in,
  input  wire logic          rd_in,
  output logic      [DW-1:0] rdata_out,
  // Expected check code from the ROM
  input  wire logic [7:0]    rom_check_code_in,
  // Check status
  output logic               check_busy_out,
  output logic               check_done_out,
  output logic               check_ok_out,
  output logic               id_valid_out
);

  // Register map, one 16-bit word per address:
  //   0x8C  Serial bits 15..0, bit 0 forced to one
  //   0x8D  Serial bits 31..16
  //   0x8E  Serial bits 39..32 below the trim byte
  //   0x8F  Calibration word a
  //   0x90  Reference trim word
  //   0x91  Calibration word b
  //   0x92  Calibration word c
  //   0xA0  Check control, read and write
  //   0xA1  Check status, read only
  // Every other address reads zero and ignores writes.

  // Check control word:
  //   bit 0  Check enable, one after reset
  //   bit 1  Restart request, write one, reads zero
  // Check status word:
  //   bit 0  Pass in progress
  //   bit 1  The last started pass has finished
  //   bit 2  Last finished pass matched the expected code
  //   bit 3  Serial holds at least two ones
  //   15:8   Running remainder, final once done is set

  // Pass timing with the clock enable high, counted from the
  // edge at which idle takes a pending, enabled pass:
  //   edge 1      Busy rises, remainder cleared
  //   edges 2-15  One byte absorbed per edge, high byte first
  //   edge 15     Also enters the compare cycle
  //   edge 16     Done and ok set, busy falls
  // Done and ok stand until the next pass starts.

  // Hazards and limits:
  //   A restart written during a pass is held, never dropped.
  //   A restart written while disabled waits for the enable.
  //   Clearing the enable does not stop a running pass.
  //   The expected code is only looked at in the compare
  //   cycle, so a code that changes mid-pass is harmless.
  //   The serial-valid bit is advice only; software still
  //   decides whether to trust the serial.
  //   Reads never stall; data stand one cycle after the strobe,
  //   and a low clock enable freezes them with all other state.

  // ROM ports
  logic [15:0] rd_word;
  logic [15:0] chk_word;
  logic [39:0] serial;
  logic [7:0]  crc_val;

  // Check sequencer
  uidr_state_t state_r;
  uidr_state_t state_nxt;
  logic [3:0]  byte_idx_r;
  logic [3:0]  byte_idx_nxt;
  logic        pend_r;
  logic        pend_nxt;
  logic        done_r;
  logic        done_nxt;
  logic        ok_r;
  logic        ok_nxt;
  logic        crc_clear;
  logic        crc_valid;
  logic [7:0]  crc_byte;

  // Control register and decoded writes
  logic        chk_en_r;
  logic        chk_en_nxt;
  logic        wr_ctrl;
  logic        go_req;

  // Serial validity
  logic        idv_r;
  logic        idv_nxt;

  // Read path
  logic [DW-1:0] rdata_r;
  logic [DW-1:0] rdata_nxt;
  logic [DW-1:0] stat_word;

  // Count of ones in the serial
  function automatic logic [5:0] ones40(input logic [39:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 40; i++) begin
      n = n + {5'h00, v[i]};
    end
    return n;
  endfunction : ones40

  // ROM image: port a serves software, port b feeds the check
  uidr_rom #(
    .UNIQUE_SERIAL   (UNIQUE_SERIAL),
    .TRIM_BYTE_UPPER (TRIM_BYTE_UPPER),
    .CAL_WORD_A      (CAL_WORD_A),
    .CAL_REF_TRIM    (CAL_REF_TRIM),
    .CAL_WORD_B      (CAL_WORD_B),
    .CAL_WORD_C      (CAL_WORD_C)
  ) u_rom (
    .idx_a_in   (uidr_rom_idx(addr_in)),
    .idx_b_in   (byte_idx_r[3:1]),
    .word_a_out (rd_word),
    .word_b_out (chk_word),
    .serial_out (serial)
  );

  // Remainder over all fourteen bank bytes
  uidr_crc8 u_crc (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .clear_in   (crc_clear),
    .valid_in   (crc_valid),
    .byte_in    (crc_byte),
    .crc_out    (crc_val)
  );

  // Write decode; only the control word takes data
  always_comb begin
    wr_ctrl = wr_in && (addr_in == ADDR_CTRL);
    go_req  = wr_ctrl && wdata_in[CTRL_GO_BIT];
  end

  // Control register; bank writes fall through untouched
  always_comb begin
    chk_en_nxt = chk_en_r;
    if (wr_ctrl) begin
      chk_en_nxt = wdata_in[CTRL_EN_BIT];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chk_en_r <= RST_CHK_EN;
    end else if (ce_in) begin
      chk_en_r <= chk_en_nxt;
    end
  end

  // High byte of each word first, words in address order
  always_comb begin
    crc_byte = byte_idx_r[0] ? chk_word[7:0] : chk_word[15:8];
  end

  // Check sequencer: a pass is pending at reset and after a restart
  // request; a request during a pass is held, so it is never lost.
  always_comb begin
    state_nxt    = state_r;
    byte_idx_nxt = byte_idx_r;
    pend_nxt     = pend_r;
    done_nxt     = done_r;
    ok_nxt       = ok_r;
    crc_clear    = 1'b0;
    crc_valid    = 1'b0;
    case (state_r)
      UIDR_IDLE: begin
        if (pend_r && chk_en_r) begin
          state_nxt    = UIDR_RUN;
          byte_idx_nxt = 4'h0;
          pend_nxt     = 1'b0;
          done_nxt     = 1'b0;
          ok_nxt       = 1'b0;
          crc_clear    = 1'b1;
        end
      end
      UIDR_RUN: begin
        crc_valid = 1'b1;
        if (byte_idx_r == LAST_BYTE) begin
          state_nxt = UIDR_CMP;
        end else begin
          byte_idx_nxt = byte_idx_r + 4'h1;
        end
      end
      UIDR_CMP: begin
        // Remainder of the last byte is in place here
        state_nxt    = UIDR_IDLE;
        byte_idx_nxt = 4'h0;
        done_nxt     = 1'b1;
        ok_nxt       = (crc_val == rom_check_code_in);
      end
      default: begin
        state_nxt    = UIDR_IDLE;
        byte_idx_nxt = 4'h0;
      end
    endcase
    // Restart set wins over the clear on leaving idle
    if (go_req) begin
      pend_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r    <= UIDR_IDLE;
      byte_idx_r <= 4'h0;
      pend_r     <= 1'b1;
      done_r     <= 1'b0;
      ok_r       <= 1'b0;
    end else if (ce_in) begin
      state_r    <= state_nxt;
      byte_idx_r <= byte_idx_nxt;
      pend_r     <= pend_nxt;
      done_r     <= done_nxt;
      ok_r       <= ok_nxt;
    end
  end

  // Serial validity, offered to software as a status bit
  always_comb begin
    idv_nxt = (ones40(serial) >= ID_MIN_ONES);
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idv_r <= 1'b0;
    end else if (ce_in) begin
      idv_r <= idv_nxt;
    end
  end

  // Status word layout
  always_comb begin
    stat_word = '0;
    stat_word[ST_BUSY_BIT] = (state_r != UIDR_IDLE);
    stat_word[ST_DONE_BIT] = done_r;
    stat_word[ST_OK_BIT]   = ok_r;
    stat_word[ST_IDV_BIT]  = idv_r;
    stat_word[ST_CRC_LSB +: 8] = crc_val;
  end

  // Read mux; data stands only in the cycle after the strobe,
  // unmapped addresses read zero
  always_comb begin
    rdata_nxt = '0;
    if (rd_in) begin
      if (uidr_in_bank(addr_in)) begin
        rdata_nxt = rd_word;
      end else if (addr_in == ADDR_CTRL) begin
        rdata_nxt[CTRL_EN_BIT] = chk_en_r;
      end else if (addr_in == ADDR_STAT) begin
        rdata_nxt = stat_word;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_r <= '0;
    end else if (ce_in) begin
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs from flip-flops; busy decoded from the state register
  assign rdata_out      = rdata_r;
  assign check_busy_out = (state_r != UIDR_IDLE);
  assign check_done_out = done_r;
  assign check_ok_out   = ok_r;
  assign id_valid_out   = idv_r;

endmodule : uidr_regs
`default_nettype wire

// [dv/uidr_regs_properties.sv]
// Port checks for the serial and calibration register bank.
// Assumes one clock, ce_in held high, bound onto uidr_regs.
`timescale 1ns/1ps
`default_nettype none
module uidr_regs_properties
  import uidr_pkg::*;
#(
  parameter logic [39:0] UNIQUE_SERIAL   = RST_SERIAL,
  parameter logic [7:0]  TRIM_BYTE_UPPER = RST_TRIM,
  parameter logic [15:0] CAL_WORD_A      = RST_WORD,
  parameter logic [15:0] CAL_REF_TRIM    = RST_WORD,
  parameter logic [15:0] CAL_WORD_B      = RST_WORD,
  parameter logic [15:0] CAL_WORD_C      = RST_WORD
) (
  // Clock, reset, enable
  input  wire logic          ref_clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          ce_in,
  // Register port
  input  wire logic [AW-1:0] addr_in,
  input  wire logic          wr_in,
  input  wire logic          rd_in,
  input  wire logic [DW-1:0] rdata_out,
  // Check status
  input  wire logic          check_busy_out,
  input  wire logic          check_done_out,
  input  wire logic          id_valid_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  // Calibration word expected at a bank address
  function automatic logic [15:0] cal_of(input logic [7:0] a);
    case (a)
      ADDR_CAL_A:  return CAL_WORD_A;
      ADDR_CAL_RF: return CAL_REF_TRIM;
      ADDR_CAL_B:  return CAL_WORD_B;
      default:     return CAL_WORD_C;
    endcase
  endfunction : cal_of

  // Read taken at one address
  sequence rd_at(logic [7:0] a);
    ce_in && rd_in && addr_in == a;
  endsequence
  // Pass body: 15 busy cycles, done low early on
  sequence pass_run;
    (check_busy_out && !check_done_out)[*8] ##1 check_busy_out[*7];
  endsequence
  sequence pass_end;
    check_done_out && !check_busy_out;
  endsequence

  // Register map reads
  serial_low_a: assert property (rd_at(ADDR_ID_LO) |=>
    rdata_out == {UNIQUE_SERIAL[15:1], 1'b1}) else $error("low word bad");
  low_bit_a: assert property (rd_at(ADDR_ID_LO) |=> rdata_out[0])
    else $error("low word bit 0 not one");
  serial_mid_a: assert property (rd_at(ADDR_ID_MID) |=>
    rdata_out == UNIQUE_SERIAL[31:16]) else $error("mid word bad");
  serial_top_a: assert property (rd_at(ADDR_ID_TOP) |=>
    rdata_out == {TRIM_BYTE_UPPER, UNIQUE_SERIAL[39:32]})
    else $error("top word bad");
  cal_word_a: assert property (ce_in && rd_in &&
    addr_in inside {[ADDR_CAL_A:ADDR_CAL_C]} |=>
    rdata_out == cal_of($past(addr_in))) else $error("cal word bad");
  // A write never drives read data
  write_quiet_a: assert property (ce_in && wr_in && !rd_in |=>
    rdata_out == 16'h0000) else $error("write changed read data");
  // Check pass timing; serial-valid flag during a pass
  pass_len_a: assert property ($rose(check_busy_out) |->
    pass_run ##1 pass_end) else $error("check pass length bad");
  id_valid_a: assert property (check_busy_out |->
    id_valid_out == ($countones({UNIQUE_SERIAL[39:1], 1'b1}) >= 2))
    else $error("serial valid flag bad");
endmodule : uidr_regs_properties

bind uidr_regs uidr_regs_properties #(
  .UNIQUE_SERIAL(UNIQUE_SERIAL), .TRIM_BYTE_UPPER(TRIM_BYTE_UPPER),
  .CAL_WORD_A(CAL_WORD_A), .CAL_REF_TRIM(CAL_REF_TRIM),
  .CAL_WORD_B(CAL_WORD_B), .CAL_WORD_C(CAL_WORD_C)
) i_uidr_regs_properties (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
  .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .check_busy_out(check_busy_out),
  .check_done_out(check_done_out), .id_valid_out(id_valid_out)
);
`default_nettype wire

// [dv/test_unique_id_calibration_rom_regs.sv]
// Self-checking bench for the serial and calibration register bank.
// Assumes uidr_regs with fixed ROM contents and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_unique_id_calibration_rom_regs
  import uidr_pkg::*;
;
  // ROM image; serial bit 0 is zero so the forced one shows
  localparam logic [39:0] SER = 40'hA5_3C96_F0E2;
  localparam logic [7:0]  TRM = 8'h5A;
  localparam logic [15:0] CWA = 16'h1234;
  localparam logic [15:0] CWR = 16'hC0DE;
  localparam logic [15:0] CWB = 16'h8001;
  localparam logic [15:0] CWC = 16'h7FFE;

  logic        ref_clk_in, rst_n_in, ce_in, wr_in, rd_in;
  logic [7:0]  addr_in, rom_check_code_in;
  logic [15:0] wdata_in, rdata_out, v;
  logic        check_busy_out, check_done_out, check_ok_out, id_valid_out;
  int          error_cnt, cmp_count, n;

  uidr_regs #(.UNIQUE_SERIAL(SER), .TRIM_BYTE_UPPER(TRM),
    .CAL_WORD_A(CWA), .CAL_REF_TRIM(CWR), .CAL_WORD_B(CWB),
    .CAL_WORD_C(CWC)) i_uidr_regs (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out),
    .rom_check_code_in(rom_check_code_in),
    .check_busy_out(check_busy_out), .check_done_out(check_done_out),
    .check_ok_out(check_ok_out), .id_valid_out(id_valid_out));

  // 40 MHz clock
  always #12.5 ref_clk_in = ~ref_clk_in;

  // Word expected at bank index i
  function automatic logic [15:0] exp_word(input int i);
    case (i)
      0: return {SER[15:1], 1'b1};
      1: return SER[31:16];
      2: return {TRM, SER[39:32]};
      3: return CWA;
      4: return CWR;
      5: return CWB;
      default: return CWC;
    endcase
  endfunction : exp_word

  // Bitwise CRC, MSB first; 0x4D is the normal form of 0xA6
  function automatic logic [7:0] exp_crc();
    logic [7:0]  c;
    logic [15:0] w;
    c = 8'h00;
    for (int i = 0; i < 7; i++) begin
      w = exp_word(i);
      for (int k = 15; k >= 0; k--)
        c = (c[7] ^ w[k]) ? ({c[6:0], 1'b0} ^ 8'h4D) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : exp_crc

  // Compare a register word
  task automatic chk_word(input string s, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk_word

  // Compare a status flag
  task automatic chk_flag(input string s, input logic e, g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", s, e, g);
    end
  endtask : chk_flag

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask : rd_reg

  // Bounded wait for a pass to finish, then check its verdict
  task automatic pass_check(input logic ok);
    repeat (2) @(posedge ref_clk_in);
    #1 chk_flag("busy", 1'b1, check_busy_out);
    for (int k = 0; k < 40 && check_done_out !== 1'b1; k++)
      @(posedge ref_clk_in);
    #1;
    chk_flag("done", 1'b1, check_done_out);
    chk_flag("ok", ok, check_ok_out);
  endtask : pass_check

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    error_cnt++;
    $display("[ERR] run expected end seen timeout");
    stop_test();
  end

  initial begin
    {ref_clk_in, rst_n_in, wr_in, rd_in} = '0;
    ce_in = 1'b1;
    addr_in = 8'h00;
    wdata_in = 16'h0000;
    rom_check_code_in = exp_crc();
    void'($urandom(94));
    repeat (8) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    // Power-up pass over the image
    pass_check(1'b1);
    chk_flag("id_valid", 1'b1, id_valid_out);
    // Control reads back enabled; status shows the finished pass
    rd_reg(ADDR_CTRL);
    chk_word("ctrl", 16'h0001, v);
    rd_reg(ADDR_STAT);
    chk_word("status", {exp_crc(), 8'h0E}, v);
    $display("Test power-up check done");
    // Full map, then random order
    for (n = 0; n < 17; n++) begin
      int i;
      i = (n < 7) ? n : int'($urandom_range(6));
      rd_reg(ADDR_ID_LO + 8'(i));
      chk_word("bank word", exp_word(i), v);
    end
    $display("Test map reads done");
    // Random writes leave every word intact
    for (n = 0; n < 7; n++) begin
      wr_reg(ADDR_ID_LO + 8'(n), 16'($urandom));
      rd_reg(ADDR_ID_LO + 8'(n));
      chk_word("after write", exp_word(n), v);
    end
    $display("Test write ignore done");
    // Unmapped reads, edges of the bank included
    for (n = 0; n < 6; n++) begin
      rd_reg((n == 0) ? 8'h8B : (n == 1) ? 8'h93 : 8'($urandom_range(139)));
      chk_word("unmapped", 16'h0000, v);
    end
    $display("Test unmapped done");
    // Low clock enable: strobes ignored, read data frozen at zero
    @(posedge ref_clk_in) ce_in <= 1'b0;
    wr_reg(ADDR_CTRL, 16'h0000);
    rd_reg(ADDR_ID_MID);
    chk_word("ce low read", 16'h0000, v);
    @(posedge ref_clk_in) ce_in <= 1'b1;
    rd_reg(ADDR_CTRL);
    chk_word("ctrl kept", 16'h0001, v);
    $display("Test clock enable done");
    // Wrong code fails; held while disabled; right code passes again
    @(posedge ref_clk_in) rom_check_code_in <= exp_crc() ^
                                               8'($urandom_range(255, 1));
    wr_reg(ADDR_CTRL, 16'h0003);
    pass_check(1'b0);
    @(posedge ref_clk_in) rom_check_code_in <= exp_crc();
    wr_reg(ADDR_CTRL, 16'h0002);
    repeat (20) @(posedge ref_clk_in);
    chk_flag("held busy", 1'b0, check_busy_out);
    wr_reg(ADDR_CTRL, 16'h0001);
    pass_check(1'b1);
    $display("Test check code done");
    stop_test();
  end
endmodule : test_unique_id_calibration_rom_regs
`default_nettype wire
